/* File: inc/sar_pkg.sv */
package sar_pkg;

  // ---------------------------------------------------------------
  // word format
  // ---------------------------------------------------------------
  localparam int RES_BITS = 16;
  localparam int CNT_W = 11;
  localparam int BIT_W = 5;

  // ---------------------------------------------------------------
  // timing figures in ns
  // ---------------------------------------------------------------
  localparam int T_CLK_NS = 10;
  localparam int T_EOC_BUSY_NS = 50;
  localparam int T_CONV_FAST_NS = 3800;
  localparam int T_CONV_SLOW_NS = 7600;
  localparam int T_DCLK_DLY_FAST_NS = 220;
  localparam int T_DCLK_DLY_SLOW_NS = 350;
  localparam int T_DCLK_PER_FAST_NS = 220;
  localparam int T_DCLK_PER_SLOW_NS = 450;
  localparam int T_PREV_FAST_NS = 3500;
  localparam int T_PREV_SLOW_NS = 7500;

  // ---------------------------------------------------------------
  // derived cycle counts (rounded up)
  // ---------------------------------------------------------------
  localparam int EOC_CYC = (T_EOC_BUSY_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int CONV_FAST_CYC =
    (T_CONV_FAST_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int CONV_SLOW_CYC =
    (T_CONV_SLOW_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int DLY_FAST_CYC =
    (T_DCLK_DLY_FAST_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int DLY_SLOW_CYC =
    (T_DCLK_DLY_SLOW_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int HALF_FAST_CYC =
    (T_DCLK_PER_FAST_NS + 2 * T_CLK_NS - 1) / (2 * T_CLK_NS);
  localparam int HALF_SLOW_CYC =
    (T_DCLK_PER_SLOW_NS + 2 * T_CLK_NS - 1) / (2 * T_CLK_NS);
  localparam int PREV_FAST_CYC =
    (T_PREV_FAST_NS + T_CLK_NS - 1) / T_CLK_NS;
  localparam int PREV_SLOW_CYC =
    (T_PREV_SLOW_NS + T_CLK_NS - 1) / T_CLK_NS;

  // ---------------------------------------------------------------
  // pin carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic conv_n;
    logic cs_n;
    logic shift_clk;
    logic ext_clk_sel;
    logic coding_twos;
  } sar_pins_in_type;

  localparam sar_pins_in_type PINS_IDLE = 5'h1C;

  typedef struct packed {
    logic busy_n;
    logic sdata;
    logic shift_clk_o;
    logic shift_clk_oe;
  } sar_pins_out_type;

endpackage : sar_pkg

/* File: rtl/sar_sync.sv */
`timescale 1ns/100ps
module sar_sync import sar_pkg::*; #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] q_ff;

  // ---------------------------------------------------------------
  // two-stage synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;

endmodule : sar_sync

/* File: rtl/sar_adc_serial_readout.sv */
`timescale 1ns/100ps
module sar_adc_serial_readout import sar_pkg::*; #(
  parameter bit FAST_GRADE = 1'b1
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire sar_pins_in_type pins_i,
  input wire logic [RES_BITS-1:0] core_code,
  output sar_pins_out_type pins_o
);

  localparam int CONV_CYC = FAST_GRADE ? CONV_FAST_CYC : CONV_SLOW_CYC;
  localparam int DLY_CYC = FAST_GRADE ? DLY_FAST_CYC : DLY_SLOW_CYC;
  localparam int HALF_CYC = FAST_GRADE ? HALF_FAST_CYC : HALF_SLOW_CYC;
  localparam int PREV_CYC = FAST_GRADE ? PREV_FAST_CYC : PREV_SLOW_CYC;
  localparam int BUSY_CYC = CONV_CYC + EOC_CYC;

  typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_TAIL} sar_state_type;

  sar_pins_in_type pins_s;
  sar_state_type state_ff, nxt_state;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [RES_BITS-1:0] sample_ff, nxt_sample;
  logic [RES_BITS-1:0] result_ff, nxt_result;
  logic busy_n_ff, nxt_busy_n;
  logic strobe_q_ff, sclk_q_ff;
  logic nxt_strobe_q, nxt_sclk_q;
  logic start;
  logic eoc;

  logic [RES_BITS-1:0] shift_ff, nxt_shift;
  logic wait_ff, nxt_wait;
  logic irun_ff, nxt_irun;
  logic iclk_ff, nxt_iclk;
  logic [CNT_W-1:0] half_ff, nxt_half;
  logic [BIT_W-1:0] nbit_ff, nxt_nbit;
  logic ext_edge;

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  sar_sync #(.WIDTH($bits(sar_pins_in_type)), .RST_VAL(PINS_IDLE))
    u_sync (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .d(pins_i),
    .q(pins_s)
  );

  always_comb begin
    nxt_strobe_q = ~pins_s.conv_n & ~pins_s.cs_n;
    nxt_sclk_q = pins_s.shift_clk;
  end

  // history starts at the synchroniser idle level: no false edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      strobe_q_ff <= 1'b0;
      sclk_q_ff <= PINS_IDLE.shift_clk;
    end else begin
      strobe_q_ff <= nxt_strobe_q;
      sclk_q_ff <= nxt_sclk_q;
    end
  end

  assign start = (state_ff == ST_IDLE) & ~pins_s.conv_n & ~pins_s.cs_n
    & ~strobe_q_ff;
  assign eoc = (state_ff == ST_CONV) && (cnt_ff == '0);

  // ---------------------------------------------------------------
  // conversion sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sample = sample_ff;
    nxt_result = result_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_CONV;
          nxt_cnt = CNT_W'(CONV_CYC - 1);
          nxt_sample = core_code;
        end
      end
      ST_CONV: begin
        if (cnt_ff == '0) begin
          nxt_result = sample_ff;
          nxt_state = ST_TAIL;
          nxt_cnt = CNT_W'(EOC_CYC - 1);
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ST_TAIL: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    nxt_busy_n = (nxt_state == ST_IDLE);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      sample_ff <= '0;
      result_ff <= '0;
      busy_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sample_ff <= nxt_sample;
      result_ff <= nxt_result;
      busy_n_ff <= nxt_busy_n;
    end
  end

  // ---------------------------------------------------------------
  // serial shifter, internal or external clock
  // ---------------------------------------------------------------
  assign ext_edge = pins_s.ext_clk_sel & ~pins_s.cs_n & pins_s.shift_clk
    & ~sclk_q_ff;

  always_comb begin
    nxt_shift = shift_ff;
    nxt_wait = wait_ff;
    nxt_irun = irun_ff;
    nxt_iclk = iclk_ff;
    nxt_half = half_ff;
    nxt_nbit = nbit_ff;
    if (start) begin
      // old word goes out while converting
      nxt_shift = {result_ff[RES_BITS-1] ^ pins_s.coding_twos,
                   result_ff[RES_BITS-2:0]};
      nxt_wait = ~pins_s.ext_clk_sel;
      nxt_irun = 1'b0;
      nxt_iclk = 1'b0;
      nxt_half = CNT_W'(DLY_CYC - 1);
    end else if (eoc) begin
      // new word ready for an external read after busy
      nxt_shift = {sample_ff[RES_BITS-1] ^ pins_s.coding_twos,
                   sample_ff[RES_BITS-2:0]};
    end else if (wait_ff) begin
      if (half_ff == '0) begin
        nxt_wait = 1'b0;
        nxt_irun = 1'b1;
        nxt_iclk = 1'b1;
        nxt_half = CNT_W'(HALF_CYC - 1);
        nxt_nbit = BIT_W'(RES_BITS - 1);
      end else begin
        nxt_half = half_ff - 1'b1;
      end
    end else if (irun_ff) begin
      if (half_ff != '0) begin
        nxt_half = half_ff - 1'b1;
      end else if (iclk_ff) begin
        nxt_iclk = 1'b0;
        nxt_shift = {shift_ff[RES_BITS-2:0], 1'b0};
        nxt_half = CNT_W'(HALF_CYC - 1);
        if (nbit_ff == '0) begin
          nxt_irun = 1'b0;
        end else begin
          nxt_nbit = nbit_ff - 1'b1;
        end
      end else begin
        nxt_iclk = 1'b1;
        nxt_half = CNT_W'(HALF_CYC - 1);
      end
    end else if (ext_edge) begin
      // rising host edge samples, then the next bit follows
      nxt_shift = {shift_ff[RES_BITS-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= '0;
      wait_ff <= 1'b0;
      irun_ff <= 1'b0;
      iclk_ff <= 1'b0;
      half_ff <= '0;
      nbit_ff <= '0;
    end else begin
      shift_ff <= nxt_shift;
      wait_ff <= nxt_wait;
      irun_ff <= nxt_irun;
      iclk_ff <= nxt_iclk;
      half_ff <= nxt_half;
      nbit_ff <= nxt_nbit;
    end
  end

  always_comb begin
    pins_o.busy_n = busy_n_ff;
    pins_o.sdata = shift_ff[RES_BITS-1];
    pins_o.shift_clk_o = iclk_ff;
    // pin driven through the start delay and while the internal clock runs
    pins_o.shift_clk_oe = wait_ff | irun_ff;
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [CNT_W-1:0] low_len_ff;
  logic [CNT_W-1:0] since_ff;
  logic [BIT_W-1:0] rises_ff;
  logic [CNT_W-1:0] nxt_low_len, nxt_since;
  logic [BIT_W-1:0] nxt_rises;

  always_comb begin
    nxt_low_len = busy_n_ff ? '0 : low_len_ff + 1'b1;
    nxt_since = start ? '0 :
      (since_ff == '1 ? since_ff : since_ff + 1'b1);
    nxt_rises = start ? '0 :
      ((nxt_iclk & ~iclk_ff) ? rises_ff + 1'b1 : rises_ff);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      low_len_ff <= '0;
      since_ff <= '0;
      rises_ff <= '0;
    end else begin
      low_len_ff <= nxt_low_len;
      since_ff <= nxt_since;
      rises_ff <= nxt_rises;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  AST_BUSY_FALL: assert property (start |=> !busy_n_ff)
    else $error("busy did not fall after start");
  AST_BUSY_LOW_LEN: assert property (
    $rose(busy_n_ff) |-> low_len_ff == CNT_W'(BUSY_CYC))
    else $error("busy low time wrong");
  AST_EOC_TO_BUSY: assert property (
    eoc |=> (!busy_n_ff)[*5] ##1 busy_n_ff)
    else $error("busy release not 50 ns after end");
  AST_RESULT_AT_EOC: assert property (
    $changed(result_ff) |-> $past(eoc))
    else $error("result changed before completion");
  AST_PREV_HELD: assert property (
    (state_ff != ST_IDLE && since_ff < CNT_W'(PREV_CYC))
      |-> $stable(result_ff))
    else $error("previous result lost early");
  // the first rise is already counted when it is seen
  AST_DCLK_DELAY: assert property (
    ($rose(iclk_ff) && rises_ff == BIT_W'(1))
      |-> since_ff == CNT_W'(DLY_CYC))
    else $error("internal clock start delay wrong");
  AST_SIXTEEN_CLOCKS: assert property (
    $fell(irun_ff) |-> rises_ff == BIT_W'(RES_BITS))
    else $error("internal burst not sixteen clocks");
  AST_CODING: assert property (
    start |=> pins_o.sdata ==
      ($past(result_ff[RES_BITS-1]) ^ $past(pins_s.coding_twos)))
    else $error("first bit coding wrong");

  COV_CONV_DONE: cover property ($rose(busy_n_ff));
  COV_INT_BURST: cover property ($fell(irun_ff));
  COV_EXT_SHIFT: cover property (ext_edge && !busy_n_ff);

endmodule : sar_adc_serial_readout

/* File: test/sar_host_model.sv */
`timescale 1ns/100ps
module sar_host_model import sar_pkg::*; (
  input wire logic clk_sys,
  input wire sar_pins_out_type pins_o,
  output sar_pins_in_type pins_i
);
  // ---------------------------------------------------------------
  // idle pins
  // ---------------------------------------------------------------
  // shift clock stands low between frames
  initial begin
    pins_i = 5'h18;
  end

  // ---------------------------------------------------------------
  // host tasks
  // ---------------------------------------------------------------
  // strobe and select together
  task automatic start(input logic ext, input logic twos);
    @(posedge clk_sys);
    #1;
    pins_i.ext_clk_sel = ext;
    pins_i.coding_twos = twos;
    pins_i.conv_n = 1'b0;
    pins_i.cs_n = 1'b0;
    while (pins_o.busy_n !== 1'b0) begin
      @(posedge clk_sys);
      #1;
    end
    // strobe kept low past the minimum pulse width
    fork
      begin
        repeat (5) @(posedge clk_sys);
        #1;
        pins_i.conv_n = 1'b1;
      end
    join_none
  endtask : start

  task automatic read_int(output logic [15:0] w, output int lead);
    lead = 0;
    w = '0;
    while (pins_o.shift_clk_o !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      lead++;
    end
    for (int i = 0; i < 16; i++) begin
      w = {w[14:0], pins_o.sdata};
      while (pins_o.shift_clk_o === 1'b1) begin
        @(posedge clk_sys);
        #1;
      end
      if (i < 15) begin
        while (pins_o.shift_clk_o !== 1'b1) begin
          @(posedge clk_sys);
          #1;
        end
      end
    end
  endtask : read_int

  // sixteen edges; when started as busy falls, done long before busy rises
  task automatic read_ext(output logic [15:0] w);
    w = '0;
    for (int i = 0; i < 16; i++) begin
      #62.5;
      w = {w[14:0], pins_o.sdata};
      pins_i.shift_clk = 1'b1;
      #62.5;
      pins_i.shift_clk = 1'b0;
    end
  endtask : read_ext
endmodule : sar_host_model

/* File: test/tb_top.sv */
`timescale 1ns/100ps
module tb_top import sar_pkg::*; ;
  logic clk_sys;
  logic arst_n;
  logic [RES_BITS-1:0] core_code;
  sar_pins_in_type pins_i;
  sar_pins_out_type pins_o;
  int bad_count;
  int comparisons;
  logic [15:0] w;
  int n;

  sar_adc_serial_readout #(.FAST_GRADE(1'b1)) uut (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .pins_i(pins_i),
    .core_code(core_code),
    .pins_o(pins_o)
  );

  sar_host_model host (
    .clk_sys(clk_sys),
    .pins_o(pins_o),
    .pins_i(pins_i)
  );

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  // counts busy cycles, first one already seen
  task automatic wait_idle();
    n = 1;
    while (pins_o.busy_n !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      if (pins_o.busy_n === 1'b0) begin
        n++;
      end
    end
  endtask : wait_idle

  task automatic set_code(input logic [15:0] c);
    @(posedge clk_sys);
    #1;
    core_code = c;
  endtask : set_code

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_busy();
    check("busy idle", {15'h0000, pins_o.busy_n}, 16'h0001);
    check("oe idle", {15'h0000, pins_o.shift_clk_oe}, 16'h0000);
    set_code(16'h1234);
    host.start(1'b0, 1'b0);
    wait_idle();
    check("busy span", 16'(n), 16'(CONV_FAST_CYC + EOC_CYC));
  endtask : t_busy

  task automatic t_int_prev();
    set_code(16'hA5C3);
    host.start(1'b0, 1'b0);
    check("oe lead", {15'h0000, pins_o.shift_clk_oe}, 16'h0001);
    host.read_int(w, n);
    check("lead", 16'(n), 16'(DLY_FAST_CYC));
    check("int word", w, 16'h1234);
    check("oe end", {15'h0000, pins_o.shift_clk_oe}, 16'h0000);
    wait_idle();
  endtask : t_int_prev

  task automatic t_ext_new();
    set_code(16'h0F0F);
    host.start(1'b1, 1'b1);
    wait_idle();
    host.read_ext(w);
    check("ext new", w, 16'h8F0F);
  endtask : t_ext_new

  task automatic t_ext_prev();
    set_code(16'h7001);
    host.start(1'b1, 1'b1);
    host.read_ext(w);
    check("ext old", w, 16'h8F0F);
    check("still busy", {15'h0000, pins_o.busy_n}, 16'h0000);
    wait_idle();
    host.read_ext(w);
    check("ext next", w, 16'hF001);
  endtask : t_ext_prev

  // ---------------------------------------------------------------
  // clock, sequence, watchdog
  // ---------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  initial begin
    arst_n = 1'b0;
    core_code = '0;
    bad_count = 0;
    comparisons = 0;
    repeat (16) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    repeat (4) @(posedge clk_sys);
    #1;
    t_busy();
    t_int_prev();
    t_ext_new();
    t_ext_prev();
    test_done();
  end

  // about five times the expected run
  initial begin
    #100000;
    $display("watchdog expired");
    bad_count++;
    test_done();
  end
endmodule : tb_top
